// ### pkg/cardbus_window_consts.svh
// Register indices, fixed fields, reset values and counts of the window block
`ifndef CARDBUS_WINDOW_CONSTS_SVH
`define CARDBUS_WINDOW_CONSTS_SVH
`define CBW_IDX_CMD 6'h04
`define CBW_IDX_LAT 6'h1b
`define CBW_IDX_MEM_BASE0 6'h1c
`define CBW_IDX_MEM_LIM0 6'h20
`define CBW_IDX_MEM_BASE1 6'h24
`define CBW_IDX_MEM_LIM1 6'h28
`define CBW_IDX_IO_BASE_LO0 6'h2c
`define CBW_IDX_IO_BASE_HI0 6'h2e
`define CBW_IDX_IO_LIM_LO0 6'h30
`define CBW_IDX_IO_LIM_HI0 6'h32
`define CBW_IDX_IO_BASE_LO1 6'h34
`define CBW_IDX_IO_BASE_HI1 6'h36
`define CBW_IDX_IO_LIM_LO1 6'h38
`define CBW_IDX_IO_LIM_HI1 6'h3a
`define CBW_IDX_IRQ_LINE 6'h3c
`define CBW_IDX_IRQ_PIN 6'h3d
`define CBW_IDX_BRG_CTL 6'h3e
`define CBW_CMD_MEM_EN_BIT 1
`define CBW_BRG_RST_BIT 6
`define CBW_BRG_RESET 16'h0340
`define CBW_BRG_WR_MASK 16'h0067
`define CBW_BRG_FIXED 16'h0300
`define CBW_IO_BASE_MASK 16'hfffc
`define CBW_PIN_SOCKET_A 8'h01
`define CBW_PIN_SOCKET_B 8'h02
`define CBW_LAT_STEP 8'h08
`define CBW_LAT_MAX_SET 8'h08
`define CBW_LAT_OFF 8'h00
`define CBW_RESP_OKAY 2'b00
`define CBW_RESP_SLVERR 2'b10
`endif

// ### pkg/cardbus_window_pkg.sv
// Types shared by the bridge window registers and their users
package cardbus_window_pkg;
   typedef struct packed {
      logic valid;
      logic is_mem;
      logic is_io;
      logic [31:0] addr;
   } cb_txn_t;
   typedef struct packed {
      logic [1:0] mem_hit;
      logic [1:0] io_hit;
      logic forward;
   } fwd_t;
   typedef struct packed {
      logic start;
      logic busy;
      logic data_done;
   } cb_master_t;
endpackage : cardbus_window_pkg

// ### rtl/cardbus_bridge_window_regs.sv
// Window registers and forwarding decode of the PCI to CardBus bridge
`timescale 1ns/1ps
`default_nettype none
`include "cardbus_window_consts.svh"
module cardbus_bridge_window_regs #(
   parameter logic [7:0] PIN_CODE = `CBW_PIN_SOCKET_A
) (
   input wire logic aclk, // Clock, 250 MHz
   input wire logic aresetn, // Sync reset, active low
   input wire logic [7:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [7:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire cardbus_window_pkg::cb_txn_t txn, // Transaction to decode
   output cardbus_window_pkg::fwd_t fwd, // Window hits
   input wire cardbus_window_pkg::cb_master_t cb_master, // Tenure status
   output logic cb_timer_expired, // CardBus latency expired
   output logic cb_master_release, // End CardBus tenure now
   output logic card_reset_out_n, // Card reset, active low
   output logic [1:0] mem_prefetch // Prefetch enable per window
);
   localparam logic [5:0] MB_IDX [2] = '{`CBW_IDX_MEM_BASE0,
                                         `CBW_IDX_MEM_BASE1};
   localparam logic [5:0] ML_IDX [2] = '{`CBW_IDX_MEM_LIM0,
                                         `CBW_IDX_MEM_LIM1};
   localparam logic [5:0] IBL_IDX [2] = '{`CBW_IDX_IO_BASE_LO0,
                                          `CBW_IDX_IO_BASE_LO1};
   localparam logic [5:0] IBH_IDX [2] = '{`CBW_IDX_IO_BASE_HI0,
                                          `CBW_IDX_IO_BASE_HI1};
   localparam logic [5:0] ILL_IDX [2] = '{`CBW_IDX_IO_LIM_LO0,
                                          `CBW_IDX_IO_LIM_LO1};

   // ==========================================================
   // State
   // ==========================================================
   logic aw_full_q;
   logic w_full_q;
   logic [5:0] aw_idx_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic [5:0] ar_idx_q;
   logic wr_fire;
   logic [32:0] wr_cur;
   logic [32:0] ar_word;
   logic [31:0] wr_val;

   logic mem_en_q;
   logic [7:0] lat_q;
   logic [7:0] irq_line_q;
   logic [15:0] brg_q;
   logic card_rst_n_q;
   logic [19:0] mem_base_q [2];
   logic [19:0] mem_lim_q [2];
   logic [15:0] io_base_lo_q [2];
   logic [15:0] io_base_hi_q [2];
   logic [15:0] io_lim_lo_q [2];
   logic [1:0] mem_hit_c;
   logic [1:0] io_hit_c;
   cardbus_window_pkg::fwd_t fwd_q;

   // ==========================================================
   // Register read decode, shared by reads and write merging
   // ==========================================================
   function automatic logic [32:0] reg_read(input logic [5:0] i);
      logic [31:0] v;
      logic ok;
      v = '0;
      ok = 1'b1;
      case (i)
         `CBW_IDX_CMD: v[`CBW_CMD_MEM_EN_BIT] = mem_en_q;
         `CBW_IDX_LAT: v[7:0] = lat_q;
         `CBW_IDX_MEM_BASE0: v = {mem_base_q[0], 12'h000};
         `CBW_IDX_MEM_BASE1: v = {mem_base_q[1], 12'h000};
         `CBW_IDX_MEM_LIM0: v = {mem_lim_q[0], 12'h000};
         `CBW_IDX_MEM_LIM1: v = {mem_lim_q[1], 12'h000};
         `CBW_IDX_IO_BASE_LO0: v[15:0] = io_base_lo_q[0];
         `CBW_IDX_IO_BASE_LO1: v[15:0] = io_base_lo_q[1];
         `CBW_IDX_IO_BASE_HI0: v[15:0] = io_base_hi_q[0];
         `CBW_IDX_IO_BASE_HI1: v[15:0] = io_base_hi_q[1];
         `CBW_IDX_IO_LIM_LO0: v[15:0] = io_lim_lo_q[0];
         `CBW_IDX_IO_LIM_LO1: v[15:0] = io_lim_lo_q[1];
         `CBW_IDX_IO_LIM_HI0: v = '0;
         `CBW_IDX_IO_LIM_HI1: v = '0;
         `CBW_IDX_IRQ_LINE: v[7:0] = irq_line_q;
         `CBW_IDX_IRQ_PIN: v[7:0] = PIN_CODE;
         `CBW_IDX_BRG_CTL: v[15:0] = brg_q;
         default: ok = 1'b0;
      endcase
      return {ok, v};
   endfunction : reg_read

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            m[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // ==========================================================
   // AXI4-Lite slave
   // ==========================================================
   assign awready = !aw_full_q;
   assign wready = !w_full_q;
   assign arready = !rvalid_q;
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   always_comb begin
      wr_cur = reg_read(aw_idx_q);
      wr_val = merge(wr_cur[31:0], wdata_q, wstrb_q);
   end

   always_comb begin
      ar_word = reg_read(araddr[7:2]);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_idx_q <= 6'h00;
      end else if (awvalid && !aw_full_q) begin
         aw_full_q <= 1'b1;
         aw_idx_q <= awaddr[7:2];
      end else if (wr_fire) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (wvalid && !w_full_q) begin
         w_full_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (wr_fire) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `CBW_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_cur[32] ? `CBW_RESP_OKAY : `CBW_RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q <= `CBW_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         ar_idx_q <= 6'h00;
      end else if (arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= ar_word[31:0];
         rresp_q <= ar_word[32] ? `CBW_RESP_OKAY : `CBW_RESP_SLVERR;
         ar_idx_q <= araddr[7:2];
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // Configuration registers
   // ==========================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_en_q <= 1'b0;
         lat_q <= 8'h00;
         irq_line_q <= 8'h00;
      end else if (wr_fire) begin
         if (aw_idx_q == `CBW_IDX_CMD) begin
            mem_en_q <= wr_val[`CBW_CMD_MEM_EN_BIT];
         end
         if (aw_idx_q == `CBW_IDX_LAT) begin
            lat_q <= wr_val[7:0];
         end
         // Kept for software only, routes nothing
         if (aw_idx_q == `CBW_IDX_IRQ_LINE) begin
            irq_line_q <= wr_val[7:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brg_q <= `CBW_BRG_RESET;
      end else if (wr_fire && aw_idx_q == `CBW_IDX_BRG_CTL) begin
         brg_q <= (wr_val[15:0] & `CBW_BRG_WR_MASK) | `CBW_BRG_FIXED;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         card_rst_n_q <= 1'b0;
      end else begin
         card_rst_n_q <= !brg_q[`CBW_BRG_RST_BIT];
      end
   end

   assign card_reset_out_n = card_rst_n_q;
   assign mem_prefetch = brg_q[9:8];

   for (genvar w = 0; w < 2; w++) begin : g_win
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            mem_base_q[w] <= 20'h0_0000;
            mem_lim_q[w] <= 20'h0_0000;
            io_base_lo_q[w] <= 16'h0000;
            io_base_hi_q[w] <= 16'h0000;
            io_lim_lo_q[w] <= 16'h0000;
         end else if (wr_fire) begin
            if (aw_idx_q == MB_IDX[w]) begin
               mem_base_q[w] <= wr_val[31:12];
            end
            if (aw_idx_q == ML_IDX[w]) begin
               mem_lim_q[w] <= wr_val[31:12];
            end
            if (aw_idx_q == IBL_IDX[w]) begin
               io_base_lo_q[w] <= wr_val[15:0] & `CBW_IO_BASE_MASK;
            end
            if (aw_idx_q == IBH_IDX[w]) begin
               io_base_hi_q[w] <= wr_val[15:0];
            end
            if (aw_idx_q == ILL_IDX[w]) begin
               io_lim_lo_q[w] <= wr_val[15:0];
            end
         end
      end

      // ========================================================
      // Window decode
      // ========================================================
      assign mem_hit_c[w] = txn.valid && txn.is_mem
         && mem_en_q
         && txn.addr[31:12] >= mem_base_q[w]
         && txn.addr[31:12] <= mem_lim_q[w];
      assign io_hit_c[w] = txn.valid && txn.is_io
         && txn.addr[31:16] == io_base_hi_q[w]
         && txn.addr[15:12] >= io_base_lo_q[w][15:12]
         && txn.addr[15:12] <= io_lim_lo_q[w][15:12];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fwd_q <= '0;
      end else begin
         fwd_q.mem_hit <= mem_hit_c;
         fwd_q.io_hit <= io_hit_c;
         fwd_q.forward <= |{mem_hit_c, io_hit_c};
      end
   end

   assign fwd = fwd_q;

   // ==========================================================
   // CardBus latency timer, separate from the PCI side timer
   // ==========================================================
   cb_latency_timer u_cb_timer (
      .aclk (aclk),
      .aresetn (aresetn),
      .setting (lat_q),
      .master (cb_master),
      .expired (cb_timer_expired),
      .release_now (cb_master_release)
   );

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   mem_low_zero_a:
   assert property (rvalid_q && ar_idx_q inside {`CBW_IDX_MEM_BASE0,
      `CBW_IDX_MEM_BASE1, `CBW_IDX_MEM_LIM0, `CBW_IDX_MEM_LIM1}
      |-> rdata_q[11:0] == 12'h000)
      else $error("memory window low bits not zero");
   io_low_zero_a:
   assert property (rvalid_q && ar_idx_q inside {`CBW_IDX_IO_BASE_LO0,
      `CBW_IDX_IO_BASE_LO1} |-> rdata_q[1:0] == 2'b00)
      else $error("IO base low bits not zero");
   io_limhi_zero_a:
   assert property (rvalid_q && ar_idx_q inside {`CBW_IDX_IO_LIM_HI0,
      `CBW_IDX_IO_LIM_HI1} |-> rdata_q == 32'h0000_0000)
      else $error("IO limit high not zero");
   pin_code_a:
   assert property (rvalid_q && ar_idx_q == `CBW_IDX_IRQ_PIN
      |-> rdata_q == {24'h00_0000, PIN_CODE})
      else $error("interrupt pin code wrong");
   prefetch_fixed_a:
   assert property (mem_prefetch == 2'b11 && brg_q[9:8] == 2'b11)
      else $error("prefetch enable not fixed");
   card_reset_a:
   assert property (wr_fire && aw_idx_q == `CBW_IDX_BRG_CTL && wstrb_q[0]
      |-> ##2 card_reset_out_n == !$past(wdata_q[6], 2))
      else $error("card reset does not follow control bit");
   mem_gate_a:
   assert property (!mem_en_q |=> fwd.mem_hit == 2'b00)
      else $error("memory forward while disabled");
   mem_hit_a:
   assert property (txn.valid && txn.is_mem && mem_en_q
      && txn.addr[31:12] == mem_lim_q[0]
      && mem_base_q[0] <= mem_lim_q[0] |=> fwd.mem_hit[0] && fwd.forward)
      else $error("memory window limit not hit");
   io_hit_a:
   assert property (txn.valid && txn.is_io
      && txn.addr[31:16] == io_base_hi_q[0]
      && txn.addr[15:12] == io_base_lo_q[0][15:12]
      && io_base_lo_q[0][15:12] <= io_lim_lo_q[0][15:12]
      |=> fwd.io_hit[0])
      else $error("IO window base not hit");
   wr_answer_a:
   assert property (awvalid && awready && wvalid && wready && !bvalid_q
      |-> ##2 bvalid)
      else $error("write answer late");
   rd_answer_a:
   assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");

   wr_done_c: cover property (wr_fire);
   io_fwd_c: cover property (fwd.io_hit[1]);
   unmapped_c: cover property (rvalid && rresp == `CBW_RESP_SLVERR);
   release_c: cover property (cb_master_release);
endmodule : cardbus_bridge_window_regs
`default_nettype wire

// ### rtl/cb_latency_timer.sv
// CardBus master latency timer
`timescale 1ns/1ps
`default_nettype none
`include "cardbus_window_consts.svh"
module cb_latency_timer (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, active low
   input wire logic [7:0] setting, // Timer setting code
   input wire cardbus_window_pkg::cb_master_t master, // Tenure status
   output logic expired, // Timer ran out in this tenure
   output logic release_now // End tenure at this data phase
);
   logic [6:0] limit;
   logic [6:0] count_q;
   logic expired_q;

   // Zero and reserved codes leave the timer idle
   always_comb begin
      if (setting == `CBW_LAT_OFF || setting > `CBW_LAT_MAX_SET) begin
         limit = 7'd0;
      end else begin
         limit = 7'(setting * `CBW_LAT_STEP);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || master.start || !master.busy) begin
         count_q <= 7'd0;
      end else if (count_q != limit) begin
         count_q <= count_q + 7'd1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || master.start || !master.busy) begin
         expired_q <= 1'b0;
      end else if (limit != 7'd0 && count_q == limit - 7'd1) begin
         expired_q <= 1'b1;
      end
   end

   assign expired = expired_q;
   // Never cut a data phase short: release on its completion
   assign release_now = expired_q && master.data_done;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   lat_idle_a:
   assert property (expired |-> limit != 7'd0)
      else $error("latency timer expired while disabled");
   release_ok_a:
   assert property (release_now |-> master.busy && expired)
      else $error("release outside an expired tenure");
   lat_expire_c: cover property (release_now);
endmodule : cb_latency_timer
`default_nettype wire

// ### sim/cb_tenure_model.sv
// CardBus master tenure source standing in for the bridge's master engine
`timescale 1ns/1ps
`default_nettype none
module cb_tenure_model (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, active low
   input wire logic go, // Hold high to request a tenure
   input wire logic slow, // Data phase every third cycle
   input wire logic release_now, // End tenure at this data phase
   output cardbus_window_pkg::cb_master_t cb_master // Tenure status
);
   logic go_q;
   logic [1:0] ph_q;
   // ==========================================================
   // Tenure sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cb_master <= '0;
         go_q <= 1'b0;
         ph_q <= 2'h0;
      end else begin
         go_q <= go;
         cb_master.start <= go && !go_q;
         ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
         if (go && !go_q) begin
            cb_master.busy <= 1'b1;
         end else if (!go || release_now) begin
            cb_master.busy <= 1'b0;
         end
         cb_master.data_done <= cb_master.busy && go && !release_now &&
                                (!slow || ph_q == 2'h2);
      end
   end
endmodule : cb_tenure_model
`default_nettype wire

// ### sim/testbench.sv
// Register bus, window decode and latency timer tests of the window block
`timescale 1ns/1ps
`default_nettype none
`include "cardbus_window_consts.svh"
module testbench;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, go, slow;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, mem_prefetch;
   logic cb_timer_expired, cb_master_release, card_reset_out_n;
   cardbus_window_pkg::cb_txn_t txn;
   cardbus_window_pkg::fwd_t fwd;
   cardbus_window_pkg::cb_master_t cb_master;
   int mismatches = 0;
   int n_checks = 0;
   localparam logic [1:0] OK = `CBW_RESP_OKAY;
   localparam logic [5:0] IDX [17] = '{`CBW_IDX_CMD, `CBW_IDX_LAT,
      `CBW_IDX_MEM_BASE0, `CBW_IDX_MEM_LIM0, `CBW_IDX_MEM_BASE1,
      `CBW_IDX_MEM_LIM1, `CBW_IDX_IO_BASE_LO0, `CBW_IDX_IO_BASE_HI0,
      `CBW_IDX_IO_LIM_LO0, `CBW_IDX_IO_LIM_HI0, `CBW_IDX_IO_BASE_LO1,
      `CBW_IDX_IO_BASE_HI1, `CBW_IDX_IO_LIM_LO1, `CBW_IDX_IO_LIM_HI1,
      `CBW_IDX_IRQ_LINE, `CBW_IDX_IRQ_PIN, `CBW_IDX_BRG_CTL};
   localparam logic [31:0] ONES [17] = '{32'h0000_0002, 32'h0000_00ff,
      32'hffff_f000, 32'hffff_f000, 32'hffff_f000, 32'hffff_f000,
      32'h0000_fffc, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_0000,
      32'h0000_fffc, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_0000,
      32'h0000_00ff, 32'h0000_0001, 32'h0000_0367};
   localparam logic [7:0] CODE [6] = '{8'h01, 8'h02, 8'h08, 8'h00, 8'h09,
      8'hff};
   cardbus_bridge_window_regs uut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .txn(txn), .fwd(fwd), .cb_master(cb_master),
      .cb_timer_expired(cb_timer_expired),
      .cb_master_release(cb_master_release),
      .card_reset_out_n(card_reset_out_n), .mem_prefetch(mem_prefetch));
   cb_tenure_model partner (.aclk(aclk), .aresetn(aresetn), .go(go),
      .slow(slow), .release_now(cb_master_release), .cb_master(cb_master));
   // ==========================================================
   // Checking and closing
   task automatic complete_run();
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic timed_out(input int k);
      if (k >= 60) begin
         mismatches++;
         $display("BAD handshake expected answer seen none");
         complete_run();
      end
   endtask : timed_out
   // ==========================================================
   // Register bus master
   task automatic axi_wr(input logic [5:0] idx, input logic [31:0] d,
                         input logic [3:0] s, input logic [1:0] er);
      int k;
      logic a, w, b;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      for (k = 0; k < 60 && !b; k++) begin
         @(negedge aclk);
         a = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end
      timed_out(k);
      chk("bresp", 32'(er), 32'(r));
   endtask : axi_wr
   task automatic axi_rd(input logic [5:0] idx, input logic [31:0] e,
                         input logic [1:0] er);
      int k;
      logic a, v;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      v = 1'b0;
      for (k = 0; k < 60 && !v; k++) begin
         @(negedge aclk);
         a = arvalid && arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (a) arvalid <= 1'b0;
         if (v) rready <= 1'b0;
      end
      timed_out(k);
      chk("rresp", 32'(er), 32'(r));
      chk("rdata", e, d);
   endtask : axi_rd
   // ==========================================================
   // Decode probe: fwd is looked at 1 ns after the edge that samples txn
   task automatic dec(input logic m, input logic io, input logic [31:0] a,
                      input logic [1:0] em, input logic [1:0] ei);
      @(posedge aclk);
      txn <= '{valid: 1'b1, is_mem: m, is_io: io, addr: a};
      @(posedge aclk);
      txn <= '0;
      #1;
      chk("mem_hit", 32'(em), 32'(fwd.mem_hit));
      chk("io_hit", 32'(ei), 32'(fwd.io_hit));
      chk("forward", 32'(|{em, ei}), 32'(fwd.forward));
   endtask : dec
   // ==========================================================
   // Latency timer run: counts edges from the taken start to expiry
   task automatic timer_run(input logic [7:0] code);
      int k;
      int lim;
      lim = (code >= 8'h01 && code <= 8'h08) ? 8 * int'(code) : 0;
      axi_wr(`CBW_IDX_LAT, {24'h00_0000, code}, 4'h1, `CBW_RESP_OKAY);
      @(posedge aclk);
      go <= 1'b1;
      slow <= code[1];
      @(posedge aclk);
      @(posedge aclk);
      for (k = 1; k <= 80; k++) begin
         @(posedge aclk);
         #1;
         if (cb_timer_expired === 1'b1) break;
      end
      chk("expiry_edges", lim == 0 ? 81 : lim, k);
      // After expiry the tenure may only end where a data phase completes
      for (k = 0; k < 8 && lim != 0 && cb_master.busy === 1'b1; k++) begin
         chk("release_mid_phase", 0,
             32'(cb_master_release & !cb_master.data_done));
         @(posedge aclk);
         #1;
      end
      chk("tenure_ended", 0, 32'(cb_master.busy & (lim != 0)));
      // The timer drops expiry one edge after the tenure ends
      @(posedge aclk);
      #1;
      chk("expired_after_end", 0, 32'(cb_timer_expired & (lim != 0)));
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : timer_run
   // ==========================================================
   // Main sequence
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, go, slow} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      txn = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      chk("reset_out_n", 0, 32'(card_reset_out_n));
      chk("prefetch", 32'h0000_0003, 32'(mem_prefetch));
      for (int i = 0; i < 17; i++) begin
         axi_rd(IDX[i],
                i == 15 ? 32'h0000_0001 : (i == 16 ? 32'h0000_0340 : 0),
                OK);
         axi_wr(IDX[i], 32'hffff_ffff, 4'hf, OK);
         axi_rd(IDX[i], ONES[i], OK);
      end
      chk("reset_out_n", 0, 32'(card_reset_out_n));
      axi_wr(`CBW_IDX_BRG_CTL, 32'h0000_0000, 4'h3, OK);
      axi_rd(`CBW_IDX_BRG_CTL, 32'h0000_0300, OK);
      chk("reset_out_n", 1, 32'(card_reset_out_n));
      axi_wr(`CBW_IDX_IRQ_LINE, 32'h0000_00a5, 4'h1, OK);
      axi_rd(`CBW_IDX_IRQ_LINE, 32'h0000_00a5, OK);
      axi_wr(6'h3f, 32'h1234_5678, 4'hf, `CBW_RESP_SLVERR);
      axi_rd(6'h3f, 32'h0000_0000, `CBW_RESP_SLVERR);
      axi_wr(`CBW_IDX_MEM_BASE0, 32'h1000_0000, 4'hf, OK);
      axi_wr(`CBW_IDX_MEM_LIM0, 32'h1000_f000, 4'hf, OK);
      axi_wr(`CBW_IDX_CMD, 32'h0000_0000, 4'h1, OK);
      dec(1'b1, 1'b0, 32'h1000_0000, 2'b00, 2'b00);
      axi_wr(`CBW_IDX_CMD, 32'h0000_0002, 4'h1, OK);
      dec(1'b1, 1'b0, 32'h1000_0000, 2'b01, 2'b00);
      dec(1'b1, 1'b0, 32'h1000_ffff, 2'b01, 2'b00);
      dec(1'b1, 1'b0, 32'h0fff_ffff, 2'b00, 2'b00);
      dec(1'b1, 1'b0, 32'h1001_0000, 2'b00, 2'b00);
      dec(1'b1, 1'b0, 32'hffff_f123, 2'b10, 2'b00);
      dec(1'b0, 1'b1, 32'h1000_0000, 2'b00, 2'b00);
      axi_wr(`CBW_IDX_IO_BASE_HI1, 32'h0000_0001, 4'h3, OK);
      axi_wr(`CBW_IDX_IO_BASE_LO1, 32'h0000_2fff, 4'h3, OK);
      axi_wr(`CBW_IDX_IO_LIM_LO1, 32'h0000_4000, 4'h3, OK);
      dec(1'b0, 1'b1, 32'h0001_2000, 2'b00, 2'b10);
      dec(1'b0, 1'b1, 32'h0001_4fff, 2'b00, 2'b10);
      dec(1'b0, 1'b1, 32'h0001_1fff, 2'b00, 2'b00);
      dec(1'b0, 1'b1, 32'h0001_5000, 2'b00, 2'b00);
      dec(1'b0, 1'b1, 32'h0002_3000, 2'b00, 2'b00);
      dec(1'b0, 1'b1, 32'hffff_f000, 2'b00, 2'b01);
      for (int i = 0; i < 6; i++) begin
         timer_run(CODE[i]);
      end
      complete_run();
   end
endmodule : testbench
`default_nettype wire
